/* hdl/msel_pkg.sv */
// constants, register map and carrier types for input conditioning and multispeed select
package msel_pkg;
    localparam int NTERM = 8;
    localparam int NSLOT = 16;
    localparam logic [7:0] FN_BIN0 = 8'h02;
    localparam logic [7:0] FN_RESET = 8'h12;
    localparam logic [7:0] FN_SF1 = 8'h20;
    localparam logic [7:0] FN_GP1 = 8'h38;
    localparam logic [7:0] FN_POS1 = 8'h42;
    localparam logic [7:0] FN_HOME_LIM = 8'h45;
    localparam logic [7:0] FN_HOME_TRIG = 8'h46;
    localparam logic [7:0] FN_FWD_INH = 8'h47;
    localparam logic [7:0] FN_REV_INH = 8'h48;
    localparam logic [7:0] FN_SPD_POS = 8'h49;
    localparam logic [7:0] FN_CNT = 8'h4A;
    localparam logic [7:0] FN_CNT_CLR = 8'h4B;
    localparam logic [7:0] FN_UNASSIGNED = 8'hFF;
    localparam logic [1:0] POL_NO = 2'h0;
    localparam logic [1:0] POL_NC = 2'h1;
    localparam logic [1:0] SCHEME_BINARY = 2'h0;
    localparam logic [1:0] SCHEME_BIT = 2'h1;
    // register byte offsets
    localparam logic [11:0] OFS_ASSIGN = 12'h000;
    localparam logic [11:0] OFS_POLARITY = 12'h020;
    localparam logic [11:0] OFS_MODE = 12'h024;
    localparam logic [11:0] OFS_SETTLE = 12'h028;
    localparam logic [11:0] OFS_START = 12'h02C;
    localparam logic [11:0] OFS_MAXF = 12'h030;
    localparam logic [11:0] OFS_STATUS = 12'h034;
    localparam logic [11:0] OFS_SLOT = 12'h040;
    // mode and polarity register fields, maximum frequency reset value
    localparam int MODE_SCHEME_LSB = 0;
    localparam int MODE_SRC_BIT = 2;
    localparam int MODE_REV_BIT = 3;
    localparam int FWD_POL_LSB = 16;
    localparam logic [15:0] MAXF_RESET = 16'hFFFF;
    typedef struct packed {
        logic [7:0] user_program_inputs;
        logic counter_count_input;
        logic counter_clear_input;
        logic [2:0] position_preset_sel;
        logic homing_limit_input;
        logic homing_trigger_input;
        logic forward_drive_inhibit;
        logic reverse_drive_inhibit;
        logic speed_position_switch;
        logic drive_reset_input;
        logic forward_run_input;
    } drive_func_s;
endpackage

/* hdl/term_cond.sv */
// input synchroniser and contact sense conditioning for nine terminals
`timescale 1ns/10ps
module term_cond (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // raw contacts, bit 8 is the forward terminal
    input wire logic [8:0] raw,
    input wire logic [8:0] nc_sel,
    input wire logic [8:0] force_no,
    // conditioned levels
    output logic [8:0] active
);
    logic [8:0] s1_r;
    logic [8:0] s2_r;
    logic [8:0] invert;

    assign invert = nc_sel & ~force_no;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active <= '0;
        end else begin
            active <= s2_r ^ invert;
        end
    end

    sense_invert_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn, 3) |-> active == ($past(raw, 3) ^ $past(invert, 1)))
        else $error("conditioned level does not follow contact and sense");
    reset_no_a: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(force_no, 1) != 9'h000) && $past(presetn, 3)
        |-> ((active ^ $past(raw, 3)) & $past(force_no, 1)) == 9'h000)
        else $error("reset terminal sensed as normally closed");
endmodule

/* hdl/settle_filter.sv */
// stability filter that accepts a binary speed index after a quiet delay
`timescale 1ns/10ps
module settle_filter (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sampled index and delay in clock cycles
    input wire logic [3:0] sel,
    input wire logic [15:0] delay,
    // accepted index
    output logic [3:0] settled
);
    logic [3:0] prev_r;
    logic [15:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= '0;
            cnt_r <= '0;
        end else if (sel != prev_r) begin
            prev_r <= sel;
            cnt_r <= '0;
        end else if (cnt_r < delay) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settled <= '0;
        end else if (sel == prev_r && cnt_r >= delay) begin
            settled <= prev_r;
        end
    end

    restart_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        sel != prev_r |=> cnt_r == 16'h0000)
        else $error("delay count not restarted on input change");
    settle_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        settled != $past(settled) |-> $past(cnt_r >= delay && sel == prev_r))
        else $error("index accepted before the delay ran out");
endmodule

/* hdl/msel_core.sv */
// terminal function assignment, polarity, multispeed select and apb registers
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
// Summary of operation
// - each programmable terminal has own sense: 00 closed true, 01 open true
// - forward terminal has its own independent sense with the same encoding
// - terminal carrying the reset function is always sensed normally open
// - scheme select 00 picks binary sixteen speeds, 01 picks bit eight speeds
// - binary mode: four select inputs form index, first is lsb
// - binary speeds 1 to 15 output frequency of slots 1 to 15
// - speed 0 uses stored slot from panel, analog sum from terminal board
// - binary selection accepted only after inputs stay stable for the delay
// - bit mode: seven inputs pick speeds 1 to 7, lowest wins, none gives 0
// - bit speeds 1 to 7 output frequency of slots 1 to 7
// - slot writes accepted only if zero or within start to maximum
// - reversible terminal-board source reverses direction when sum below zero
// - codes 56 to 63 route terminals to user program inputs one to eight
// - codes 66 to 68 position select bits, 69 and 70 homing inputs
// - codes 71 and 72 drive stop inputs, 73 speed/position switch
// - a function lives on one terminal; reassignment unassigns earlier holders
module msel_core (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // contacts: eight programmable terminals and forward terminal
    input wire logic [7:0] term_contact,
    input wire logic forward_contact,
    // analog commands, signed, in 0.01 Hz
    input wire logic signed [15:0] main_analog,
    input wire logic signed [15:0] aux_analog,
    // drive outputs
    output msel_pkg::drive_func_s drive_func,
    output logic [15:0] speed_frequency,
    output logic [3:0] speed_index,
    output logic direction_reverse
);
    import msel_pkg::*;

    logic [7:0] terminal_function_assign [NTERM];
    logic [15:0] preset_frequency_slots [NSLOT];
    logic [1:0] terminal_polarity_settings [NTERM];
    logic [1:0] forward_terminal_polarity;
    logic [1:0] multispeed_scheme_select;
    logic frequency_source_select;
    logic reversible_analog;
    logic [15:0] selection_settle_delay;
    logic [15:0] start_freq_r;
    logic [15:0] max_freq_r;
    logic reject_r;
    logic [8:0] nc_sel;
    logic [8:0] force_no;
    logic [8:0] active;
    logic [7:0] term_active;
    logic [3:0] bin_raw;
    logic [3:0] bin_settled;
    logic [6:0] sf_in;
    logic [3:0] idx_nxt;
    logic signed [16:0] analog_sum;
    logic [16:0] analog_mag;
    logic [15:0] freq_nxt;
    logic reverse_nxt;
    logic wr_en;
    logic rd_setup;
    logic [7:0] wr_code;
    logic slot_ok;
    logic [31:0] rdata_nxt;

    // level of the terminal that holds a function code
    function automatic logic func_level(input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NTERM; i++) begin
            if (terminal_function_assign[i] == code) begin
                hit = hit | term_active[i];
            end
        end
        return hit;
    endfunction

    function automatic logic is_assign(input logic [11:0] a);
        return a[11:5] == OFS_ASSIGN[11:5];
    endfunction

    function automatic logic is_slot(input logic [11:0] a);
        return a[11:6] == OFS_SLOT[11:6];
    endfunction

    function automatic logic addr_ok(input logic [11:0] a);
        return is_assign(a) || is_slot(a) || a == OFS_POLARITY || a == OFS_MODE ||
            a == OFS_SETTLE || a == OFS_START || a == OFS_MAXF || a == OFS_STATUS;
    endfunction

    // apb decode, zero wait states
    assign wr_en = psel && penable && pwrite && addr_ok(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign wr_code = pwdata[7:0];
    assign slot_ok = (pwdata[15:0] == 16'h0000) ||
        (pwdata[15:0] >= start_freq_r && pwdata[15:0] <= max_freq_r);

    // function assignment with single holder
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NTERM; i++) begin
                terminal_function_assign[i] <= FN_UNASSIGNED;
            end
        end else if (wr_en && is_assign(paddr)) begin
            for (int i = 0; i < NTERM; i++) begin
                if (i == int'(paddr[4:2])) begin
                    terminal_function_assign[i] <= wr_code;
                end else if (terminal_function_assign[i] == wr_code) begin
                    terminal_function_assign[i] <= FN_UNASSIGNED;
                end
            end
        end
    end

    // frequency slots with range check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSLOT; i++) begin
                preset_frequency_slots[i] <= 16'h0000;
            end
            reject_r <= 1'b0;
        end else if (wr_en && is_slot(paddr)) begin
            reject_r <= !slot_ok;
            if (slot_ok) begin
                preset_frequency_slots[paddr[5:2]] <= pwdata[15:0];
            end
        end
    end

    // polarity, mode and limits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NTERM; i++) begin
                terminal_polarity_settings[i] <= POL_NO;
            end
            forward_terminal_polarity <= POL_NO;
            multispeed_scheme_select <= SCHEME_BINARY;
            frequency_source_select <= 1'b0;
            reversible_analog <= 1'b0;
            selection_settle_delay <= 16'h0000;
            start_freq_r <= 16'h0000;
            max_freq_r <= MAXF_RESET;
        end else if (wr_en) begin
            if (paddr == OFS_POLARITY) begin
                for (int i = 0; i < NTERM; i++) begin
                    terminal_polarity_settings[i] <= pwdata[2*i +: 2];
                end
                forward_terminal_polarity <= pwdata[FWD_POL_LSB +: 2];
            end
            if (paddr == OFS_MODE) begin
                multispeed_scheme_select <= pwdata[MODE_SCHEME_LSB +: 2];
                frequency_source_select <= pwdata[MODE_SRC_BIT];
                reversible_analog <= pwdata[MODE_REV_BIT];
            end
            if (paddr == OFS_SETTLE) begin
                selection_settle_delay <= pwdata[15:0];
            end
            if (paddr == OFS_START) begin
                start_freq_r <= pwdata[15:0];
            end
            if (paddr == OFS_MAXF) begin
                max_freq_r <= pwdata[15:0];
            end
        end
    end

    // sense selection per terminal
    generate
        for (genvar g = 0; g < NTERM; g++) begin : g_sense
            assign nc_sel[g] = terminal_polarity_settings[g] == POL_NC;
            assign force_no[g] = terminal_function_assign[g] == FN_RESET;
        end
    endgenerate
    assign nc_sel[8] = forward_terminal_polarity == POL_NC;
    assign force_no[8] = 1'b0;

    term_cond term_cond_i (
        .pclk(pclk),
        .presetn(presetn),
        .raw({forward_contact, term_contact}),
        .nc_sel(nc_sel),
        .force_no(force_no),
        .active(active)
    );

    assign term_active = active[7:0];

    // process form, so that reads inside func_level wake it
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            bin_raw[i] = func_level(FN_BIN0 + 8'(i));
        end
        for (int i = 0; i < 7; i++) begin
            sf_in[i] = func_level(FN_SF1 + 8'(i));
        end
    end

    settle_filter settle_filter_i (
        .pclk(pclk),
        .presetn(presetn),
        .sel(bin_raw),
        .delay(selection_settle_delay),
        .settled(bin_settled)
    );

    // speed index and frequency
    assign analog_sum = 17'(main_analog) + 17'(aux_analog);
    assign analog_mag = analog_sum[16] ? 17'(-analog_sum) : 17'(analog_sum);

    always_comb begin
        idx_nxt = 4'h0;
        case (multispeed_scheme_select)
            SCHEME_BINARY: idx_nxt = bin_settled;
            SCHEME_BIT: begin
                for (int i = 6; i >= 0; i--) begin
                    if (sf_in[i]) begin
                        idx_nxt = 4'(i + 1);
                    end
                end
            end
            default: idx_nxt = 4'h0;
        endcase
        if (idx_nxt != 4'h0) begin
            freq_nxt = preset_frequency_slots[idx_nxt];
        end else if (frequency_source_select) begin
            freq_nxt = analog_mag[16] ? 16'hFFFF : analog_mag[15:0];
        end else begin
            freq_nxt = preset_frequency_slots[0];
        end
        reverse_nxt = frequency_source_select && reversible_analog && analog_sum[16];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_index <= 4'h0;
            speed_frequency <= 16'h0000;
            direction_reverse <= 1'b0;
        end else begin
            speed_index <= idx_nxt;
            speed_frequency <= freq_nxt;
            direction_reverse <= reverse_nxt;
        end
    end

    // function routing to drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_func <= '0;
        end else begin
            for (int i = 0; i < NTERM; i++) begin
                drive_func.user_program_inputs[i] <= func_level(FN_GP1 + 8'(i));
            end
            for (int i = 0; i < 3; i++) begin
                drive_func.position_preset_sel[i] <= func_level(FN_POS1 + 8'(i));
            end
            drive_func.counter_count_input <= func_level(FN_CNT);
            drive_func.counter_clear_input <= func_level(FN_CNT_CLR);
            drive_func.homing_limit_input <= func_level(FN_HOME_LIM);
            drive_func.homing_trigger_input <= func_level(FN_HOME_TRIG);
            drive_func.forward_drive_inhibit <= func_level(FN_FWD_INH);
            drive_func.reverse_drive_inhibit <= func_level(FN_REV_INH);
            drive_func.speed_position_switch <= func_level(FN_SPD_POS);
            drive_func.drive_reset_input <= func_level(FN_RESET);
            drive_func.forward_run_input <= active[8];
        end
    end

    // read data captured in the setup cycle
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (is_assign(paddr)) begin
            rdata_nxt[7:0] = terminal_function_assign[paddr[4:2]];
        end else if (is_slot(paddr)) begin
            rdata_nxt[15:0] = preset_frequency_slots[paddr[5:2]];
        end else begin
            case (paddr)
                OFS_POLARITY: begin
                    for (int i = 0; i < NTERM; i++) begin
                        rdata_nxt[2*i +: 2] = terminal_polarity_settings[i];
                    end
                    rdata_nxt[FWD_POL_LSB +: 2] = forward_terminal_polarity;
                end
                OFS_MODE: begin
                    rdata_nxt[MODE_SCHEME_LSB +: 2] = multispeed_scheme_select;
                    rdata_nxt[MODE_SRC_BIT] = frequency_source_select;
                    rdata_nxt[MODE_REV_BIT] = reversible_analog;
                end
                OFS_SETTLE: rdata_nxt[15:0] = selection_settle_delay;
                OFS_START: rdata_nxt[15:0] = start_freq_r;
                OFS_MAXF: rdata_nxt[15:0] = max_freq_r;
                OFS_STATUS: rdata_nxt = {direction_reverse, reject_r, 1'b0, active,
                    speed_index, speed_frequency};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rdata_nxt;
        end
    end

    // checks
    single_holder_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && is_assign(paddr) && wr_code != FN_UNASSIGNED |=>
        terminal_function_assign[$past(paddr[4:2])] == $past(wr_code) &&
        terminal_function_assign[$past(paddr[4:2]) ^ 3'h1] != $past(wr_code))
        else $error("function left on more than one terminal");
    range_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && is_slot(paddr) && !slot_ok |=>
        preset_frequency_slots[$past(paddr[5:2])] ==
        $past(preset_frequency_slots[paddr[5:2]]) && reject_r)
        else $error("out of range slot write was stored");
    binary_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
        multispeed_scheme_select == SCHEME_BINARY && bin_settled != 4'h0 |=>
        speed_index == $past(bin_settled) &&
        speed_frequency == $past(preset_frequency_slots[bin_settled]))
        else $error("binary speed does not output its slot");
    bit_priority_a: assert property (@(posedge pclk) disable iff (!presetn)
        multispeed_scheme_select == SCHEME_BIT && sf_in[0] |=> speed_index == 4'h1)
        else $error("lowest select input did not win");
    panel_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        idx_nxt == 4'h0 && !frequency_source_select |=>
        speed_frequency == $past(preset_frequency_slots[0]))
        else $error("speed zero not taken from stored setting");
    reverse_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 direction_reverse == $past(frequency_source_select && reversible_analog &&
        (32'(main_analog) + 32'(aux_analog) < 0)))
        else $error("direction reversal does not follow analog sum");
    user_input_a: assert property (@(posedge pclk) disable iff (!presetn)
        terminal_function_assign[0] == FN_GP1 |=>
        drive_func.user_program_inputs[0] == $past(term_active[0]))
        else $error("user program input not routed");
endmodule

/* sim/contact_bank.sv */
// far side model: switch contacts wired to the terminals
`timescale 1ns/10ps
module contact_bank (
    // clock
    input wire logic pclk,
    // wanted state, bit 8 forward terminal, 1 = closed
    input wire logic [8:0] want,
    // contacts
    output logic [7:0] term_contact,
    output logic forward_contact
);
    initial begin
        term_contact = 8'h00;
        forward_contact = 1'b0;
    end
    // contacts move just after an edge, never on it
    always @(posedge pclk) begin
        term_contact <= want[7:0];
        forward_contact <= want[8];
    end
endmodule

/* sim/msel_core_tb.sv */
// self-checking bench for terminal conditioning and multispeed select
`timescale 1ns/10ps
module msel_core_tb;
    import msel_pkg::*;
    localparam int SETTLE = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic err;
    logic [8:0] want = 9'h000;
    logic [7:0] term_contact;
    logic forward_contact;
    logic signed [15:0] main_a = 16'sh0000;
    logic signed [15:0] aux_a = 16'sh0000;
    drive_func_s df;
    logic [15:0] freq;
    logic [3:0] idx;
    logic rev;
    int mismatches = 0;
    int samples_checked = 0;
    always #5 pclk = ~pclk;
    contact_bank contact_bank_i (.pclk(pclk), .want(want), .term_contact(term_contact),
        .forward_contact(forward_contact));
    msel_core msel_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .term_contact(term_contact), .forward_contact(forward_contact),
        .main_analog(main_a), .aux_analog(aux_a), .drive_func(df), .speed_frequency(freq),
        .speed_index(idx), .direction_reverse(rev));
    task end_sim();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    function automatic logic [31:0] sv(input int i);
        return 32'(i * 37 + 10);
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            end_sim();
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        apb(1'b0, a, 32'h0000_0000, q);
        chk(q, exp, what);
    endtask
    task t_reset();
        rdc(OFS_ASSIGN, 32'h0000_00FF, "assign reset");
        rdc(OFS_MAXF, 32'h0000_FFFF, "max reset");
        rdc(12'h100, 32'h0000_0000, "unmapped data");
        chk(32'(err), 32'h1, "unmapped error");
        $display("test reset done");
    endtask
    task t_codes();
        logic [7:0] c [10];
        drive_func_s e;
        c = '{FN_POS1, FN_POS1 + 8'h01, FN_POS1 + 8'h02, FN_HOME_LIM, FN_HOME_TRIG,
            FN_FWD_INH, FN_REV_INH, FN_SPD_POS, FN_CNT, FN_CNT_CLR};
        want <= 9'h001;
        for (int i = 0; i < 10; i++) begin
            wr(OFS_ASSIGN, 32'(c[i]));
            cyc(8);
            e = '0;
            case (i)
                0, 1, 2: e.position_preset_sel[i] = 1'b1;
                3: e.homing_limit_input = 1'b1;
                4: e.homing_trigger_input = 1'b1;
                5: e.forward_drive_inhibit = 1'b1;
                6: e.reverse_drive_inhibit = 1'b1;
                7: e.speed_position_switch = 1'b1;
                8: e.counter_count_input = 1'b1;
                default: e.counter_clear_input = 1'b1;
            endcase
            chk(32'(df), 32'(e), "function route");
        end
        $display("test function codes done");
    endtask
    task gp(input logic [31:0] pol, input logic [7:0] u, input logic f);
        wr(OFS_POLARITY, pol);
        cyc(8);
        chk(32'(df.user_program_inputs), 32'(u), "general inputs");
        chk(32'(df.forward_run_input), 32'(f), "forward input");
    endtask
    task t_sense();
        for (int i = 0; i < 8; i++) begin
            wr(OFS_ASSIGN + 12'(4 * i), 32'(FN_GP1 + 8'(i)));
        end
        want <= 9'h0A5;
        gp(32'h0000_0000, 8'hA5, 1'b0);
        gp(32'h0000_5555, 8'h5A, 1'b0);
        gp(32'h0001_0000, 8'hA5, 1'b1);
        wr(OFS_ASSIGN + 12'h004, 32'(FN_RESET));
        wr(OFS_ASSIGN + 12'h008, 32'(FN_RESET));
        rdc(OFS_ASSIGN + 12'h004, 32'h0000_00FF, "earlier holder");
        rdc(OFS_ASSIGN + 12'h008, 32'(FN_RESET), "new holder");
        want <= 9'h000;
        wr(OFS_POLARITY, 32'h0000_0010);
        cyc(8);
        chk(32'(df.drive_reset_input), 32'h0, "reset open");
        want <= 9'h004;
        cyc(8);
        chk(32'(df.drive_reset_input), 32'h1, "reset closed");
        wr(OFS_POLARITY, 32'h0000_0000);
        $display("test sense and assignment done");
    endtask
    task t_binary();
        for (int i = 0; i < 16; i++) begin
            wr(OFS_SLOT + 12'(4 * i), sv(i));
        end
        for (int i = 0; i < 4; i++) begin
            wr(OFS_ASSIGN + 12'(4 * i), 32'(FN_BIN0 + 8'(i)));
        end
        wr(OFS_SETTLE, 32'(SETTLE));
        wr(OFS_MODE, 32'h0000_0000);
        for (int i = 0; i < 16; i++) begin
            want <= 9'(i);
            cyc(SETTLE + 12);
            chk(32'(idx), 32'(i), "binary index");
            chk(32'(freq), sv(i), "binary freq");
        end
        for (int k = 0; k < 6; k++) begin
            want <= 9'h006;
            cyc(SETTLE / 2);
            want <= 9'h00F;
            cyc(SETTLE / 2);
            chk(32'(idx), 32'hF, "index held");
        end
        want <= 9'h006;
        cyc(SETTLE - 2);
        chk(32'(idx), 32'hF, "not yet settled");
        cyc(14);
        chk(32'(idx), 32'h6, "settled");
        $display("test binary mode done");
    endtask
    task zs(input logic [31:0] mode, input logic [31:0] f, input logic r);
        wr(OFS_MODE, mode);
        cyc(6);
        chk(32'(freq), f, "speed zero freq");
        chk(32'(rev), 32'(r), "direction");
    endtask
    task t_zero();
        want <= 9'h000;
        main_a <= 16'sh012C;
        aux_a <= 16'shFE0C;
        cyc(SETTLE + 12);
        zs(32'h0000_000C, 32'h0000_00C8, 1'b1);
        zs(32'h0000_0004, 32'h0000_00C8, 1'b0);
        zs(32'h0000_0000, sv(0), 1'b0);
        $display("test speed zero done");
    endtask
    task t_bit();
        for (int i = 0; i < 7; i++) begin
            wr(OFS_ASSIGN + 12'(4 * i), 32'(FN_SF1 + 8'(i)));
        end
        wr(OFS_MODE, 32'h0000_0001);
        for (int k = 0; k <= 7; k++) begin
            want <= 9'(7'h7F << k);
            cyc(8);
            chk(32'(idx), 32'((k + 1) % 8), "bit index");
            chk(32'(freq), sv((k + 1) % 8), "bit freq");
        end
        $display("test bit mode done");
    endtask
    task slot(input logic [31:0] d, input logic [31:0] exp, input logic rej);
        wr(OFS_SLOT + 12'h008, d);
        rdc(OFS_SLOT + 12'h008, exp, "slot value");
        rdc(OFS_STATUS, (32'(rej) << 30) | sv(0), "reject flag");
    endtask
    task t_range();
        wr(OFS_START, 32'h0000_0064);
        wr(OFS_MAXF, 32'h0000_03E8);
        want <= 9'h000;
        wr(OFS_MODE, 32'h0000_0003);
        cyc(8);
        slot(32'h0000_0032, sv(2), 1'b1);
        slot(32'h0000_0000, 32'h0000_0000, 1'b0);
        slot(32'h0000_03E9, 32'h0000_0000, 1'b1);
        slot(32'h0000_03E8, 32'h0000_03E8, 1'b0);
        slot(32'h0000_0064, 32'h0000_0064, 1'b0);
        $display("test slot range done");
    endtask
    initial begin
        cyc(5);
        presetn <= 1'b1;
        t_reset();
        t_codes();
        t_sense();
        t_binary();
        t_zero();
        t_bit();
        t_range();
        end_sim();
    end
endmodule
